// >>> hdl/slocfg_top.sv
`timescale 1ns/1ns
module slocfg_top (
	input  wire logic                                       clk,
	input  wire logic                                       rst,
	input  wire logic                                       ce,
	input  wire logic                                       psel,
	input  wire logic                                       penable,
	input  wire logic                                       pwrite,
	input  wire logic [slocfg_pkg::ADDR_W-1:0]              paddr,
	input  wire logic [slocfg_pkg::DATA_W-1:0]              pwdata,
	output logic      [slocfg_pkg::DATA_W-1:0]              prdata,
	output logic                                            pready,
	output logic                                            pslverr,
	input  wire logic [slocfg_pkg::LANES-1:0]               lane_data,
	output slocfg_pkg::slocfg_lane_out_t [slocfg_pkg::LANES-1:0] lane_out,
	input  wire logic                                       sync_diff_p,
	input  wire logic                                       sync_diff_m,
	input  wire logic                                       general_purpose_pin_four,
	output logic                                            sync_req_n
);
	import slocfg_pkg::*;

	// All module state
	typedef struct packed {
		slocfg_regs_t        regs;
		logic                pready;
		logic                pslverr;
		logic [DATA_W-1:0]   prdata;
		logic                sync_req_n;
		logic                diff_level;
	} slocfg_state_t;

	slocfg_state_t state_q;
	slocfg_state_t state_d;

	// Bus phase terms
	logic setup_phase;
	logic access_done;
	logic addr_hit;
	logic [DATA_W-1:0] read_word;
	logic [5:0] idx;

	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable & state_q.pready;
	assign idx         = paddr[ADDR_W-1:2];

	// Address decode and read data
	always_comb begin
		addr_hit  = 1'b1;
		read_word = '0;
		if (paddr[1:0] != 2'b00) begin
			addr_hit = 1'b0;
		end else if (idx == IDX_LANE_POL) begin
			// Invert bits are write-only and read as zero
			read_word[POL_RSV_LSB +: POL_RSV_W] = state_q.regs.pol_rsv;
		end else if (idx == IDX_DEEMPH0) begin
			read_word[DEEMPH_LSB +: DEEMPH_W] = state_q.regs.lane_deemphasis_level[0];
		end else if (idx == IDX_DEEMPH1) begin
			read_word[DEEMPH_LSB +: DEEMPH_W] = state_q.regs.lane_deemphasis_level[1];
		end else if (idx == IDX_DEEMPH2) begin
			read_word[DEEMPH_LSB +: DEEMPH_W] = state_q.regs.lane_deemphasis_level[2];
		end else if (idx == IDX_DEEMPH3) begin
			read_word[DEEMPH_LSB +: DEEMPH_W] = state_q.regs.lane_deemphasis_level[3];
		end else if (idx == IDX_SYNC_SEL) begin
			read_word[SYNC_SEL_BIT] = state_q.regs.single_ended_sync_select;
		end else if (idx == IDX_STATUS) begin
			read_word[STAT_SYNC_BIT] = state_q.sync_req_n;
			read_word[STAT_SEL_BIT]  = state_q.regs.single_ended_sync_select;
			read_word[STAT_DIFF_BIT] = state_q.diff_level;
		end else begin
			addr_hit = 1'b0;
		end
	end

	// Next state: bus answer, register writes, sync source mux
	always_comb begin
		state_d = state_q;

		// Answer is prepared in the setup cycle and held one access cycle
		if (setup_phase) begin
			state_d.pready  = 1'b1;
			state_d.pslverr = ~addr_hit;
			state_d.prdata  = pwrite ? RDATA_RESET : read_word;
		end else if (access_done) begin
			state_d.pready  = 1'b0;
			state_d.pslverr = 1'b0;
			state_d.prdata  = RDATA_RESET;
		end

		// Writes land at the completing access edge
		if (access_done && pwrite && addr_hit) begin
			if (idx == IDX_LANE_POL) begin
				state_d.regs.lane_invert_bits = pwdata[POL_LSB +: POL_W];
				state_d.regs.pol_rsv          = pwdata[POL_RSV_LSB +: POL_RSV_W];
			end else if (idx == IDX_DEEMPH0) begin
				state_d.regs.lane_deemphasis_level[0] = pwdata[DEEMPH_LSB +: DEEMPH_W];
			end else if (idx == IDX_DEEMPH1) begin
				state_d.regs.lane_deemphasis_level[1] = pwdata[DEEMPH_LSB +: DEEMPH_W];
			end else if (idx == IDX_DEEMPH2) begin
				state_d.regs.lane_deemphasis_level[2] = pwdata[DEEMPH_LSB +: DEEMPH_W];
			end else if (idx == IDX_DEEMPH3) begin
				state_d.regs.lane_deemphasis_level[3] = pwdata[DEEMPH_LSB +: DEEMPH_W];
			end else if (idx == IDX_SYNC_SEL) begin
				state_d.regs.single_ended_sync_select = pwdata[SYNC_SEL_BIT];
			end
		end

		// Differential receiver: equal legs keep the last decision
		if (!state_q.regs.single_ended_sync_select) begin
			if (sync_diff_p != sync_diff_m) begin
				state_d.diff_level = sync_diff_p;
			end
			state_d.sync_req_n = (sync_diff_p != sync_diff_m) ? sync_diff_p : state_q.diff_level;
		end else begin
			// Pair is not looked at while pin four is the source
			state_d.sync_req_n = general_purpose_pin_four;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= '{regs: '0, pready: 1'b0, pslverr: 1'b0, prdata: RDATA_RESET,
			             sync_req_n: 1'b1, diff_level: 1'b1};
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	// Lane output stages; invert bits map in reverse lane order
	for (genvar i = 0; i < LANES; i++) begin : g_lane
		slocfg_lane u_lane (
			.clk      (clk),
			.rst      (rst),
			.ce       (ce),
			.data     (lane_data[i]),
			.invert   (state_q.regs.lane_invert_bits[LANES-1-i]),
			.level    (state_q.regs.lane_deemphasis_level[i]),
			.lane_out (lane_out[i])
		);
	end

	// Outputs straight from flip-flops
	assign prdata     = state_q.prdata;
	assign pready     = state_q.pready;
	assign pslverr    = state_q.pslverr;
	assign sync_req_n = state_q.sync_req_n;

endmodule : slocfg_top

// >>> hdl/slocfg_pkg.sv
package slocfg_pkg;

	// Bus widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int LANES  = 4;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_LANE_POL  = 6'h17;
	localparam logic [5:0] IDX_DEEMPH0   = 6'h32;
	localparam logic [5:0] IDX_DEEMPH1   = 6'h33;
	localparam logic [5:0] IDX_DEEMPH2   = 6'h34;
	localparam logic [5:0] IDX_DEEMPH3   = 6'h35;
	localparam logic [5:0] IDX_SYNC_SEL  = 6'h36;
	localparam logic [5:0] IDX_STATUS    = 6'h3f;

	// Field positions and widths
	localparam int POL_LSB       = 0;
	localparam int POL_W         = 4;
	localparam int POL_RSV_LSB   = 4;
	localparam int POL_RSV_W     = 3;
	localparam int DEEMPH_LSB    = 2;
	localparam int DEEMPH_W      = 6;
	localparam int SYNC_SEL_BIT  = 6;
	localparam int STAT_SYNC_BIT = 0;
	localparam int STAT_SEL_BIT  = 1;
	localparam int STAT_DIFF_BIT = 2;

	// Reset values
	localparam logic [7:0]  REG_RESET   = 8'h00;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	// De-emphasis codes with a defined strength
	localparam logic [5:0] DE_CODE_0DB   = 6'h00;
	localparam logic [5:0] DE_CODE_1DB   = 6'h01;
	localparam logic [5:0] DE_CODE_2DB   = 6'h03;
	localparam logic [5:0] DE_CODE_4P1DB = 6'h07;
	localparam logic [5:0] DE_CODE_6P2DB = 6'h0f;

	typedef enum logic [2:0] {
		DE_NONE,
		DE_1DB,
		DE_2DB,
		DE_4P1DB,
		DE_6P2DB,
		DE_OTHER
	} slocfg_step_t;

	// One lane's driven state
	typedef struct packed {
		logic                tx_p;
		logic                tx_m;
		logic [DEEMPH_W-1:0] level;
		slocfg_step_t        step;
	} slocfg_lane_out_t;

	// Stored register fields
	typedef struct packed {
		logic [POL_W-1:0]                lane_invert_bits;
		logic [POL_RSV_W-1:0]            pol_rsv;
		logic [LANES-1:0][DEEMPH_W-1:0]  lane_deemphasis_level;
		logic                            single_ended_sync_select;
	} slocfg_regs_t;

	// Byte address of a register index
	function automatic logic [ADDR_W-1:0] reg_addr(input logic [5:0] idx);
		return {idx, 2'b00};
	endfunction : reg_addr

	// Maps a de-emphasis code to its strength
	function automatic slocfg_step_t decode_step(input logic [DEEMPH_W-1:0] code);
		slocfg_step_t s;
		s = DE_OTHER;
		if (code == DE_CODE_0DB) begin
			s = DE_NONE;
		end else if (code == DE_CODE_1DB) begin
			s = DE_1DB;
		end else if (code == DE_CODE_2DB) begin
			s = DE_2DB;
		end else if (code == DE_CODE_4P1DB) begin
			s = DE_4P1DB;
		end else if (code == DE_CODE_6P2DB) begin
			s = DE_6P2DB;
		end
		return s;
	endfunction : decode_step

endpackage : slocfg_pkg

// >>> hdl/slocfg_lane.sv
`timescale 1ns/1ns
module slocfg_lane (
	input  wire logic                             clk,
	input  wire logic                             rst,
	input  wire logic                             ce,
	input  wire logic                             data,
	input  wire logic                             invert,
	input  wire logic [slocfg_pkg::DEEMPH_W-1:0]  level,
	output slocfg_pkg::slocfg_lane_out_t          lane_out
);
	import slocfg_pkg::*;

	slocfg_lane_out_t state_q;
	slocfg_lane_out_t state_d;

	// Leg drive, with legs swapped when inverted, and strength decode
	always_comb begin
		state_d       = state_q;
		state_d.tx_p  = data ^ invert;
		state_d.tx_m  = ~(data ^ invert);
		state_d.level = level;
		state_d.step  = decode_step(level);
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= '{tx_p: 1'b0, tx_m: 1'b1, level: '0, step: DE_NONE};
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	assign lane_out = state_q;

endmodule : slocfg_lane

// >>> verif/slocfg_props.sv
`timescale 1ns/1ns
module slocfg_props
(
	input wire logic                               clk,
	input wire logic                               rst,
	input wire logic                               psel,
	input wire logic                               penable,
	input wire logic [7:0]                         paddr,
	input wire logic [31:0]                        prdata,
	input wire logic                               pready,
	input wire logic                               pslverr,
	input slocfg_pkg::slocfg_lane_out_t [3:0]      lane_out,
	input wire logic                               sync_diff_p,
	input wire logic                               sync_diff_m,
	input wire logic                               general_purpose_pin_four,
	input wire logic                               sync_req_n
);
	import slocfg_pkg::*;
	// Bus answer, lane output and sync request relations
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_READY_NEXT: assert property (psel && !penable |=> pready) else $error("setup not answered");
	AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready held");
	AST_READY_IDLE: assert property (!psel |=> !pready) else $error("ready without select");
	AST_RDATA_ZERO: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
	AST_ERR_ALIGN: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr) else $error("misalign ok");
	AST_ERR_READY: assert property (pslverr |-> pready) else $error("error without ready");
	AST_LEGS: assert property (lane_out[0].tx_m != lane_out[0].tx_p && lane_out[3].tx_m != lane_out[3].tx_p)
		else $error("legs not opposite");
	AST_STEP: assert property (lane_out[1].level == 6'h0f |-> lane_out[1].step == DE_6P2DB)
		else $error("step decode wrong");
	AST_SYNC: assert property (!$past(rst) && $past(sync_diff_p) != $past(sync_diff_m)
		&& $past(sync_diff_p) == $past(general_purpose_pin_four) |-> sync_req_n == $past(sync_diff_p))
		else $error("sync request wrong");
	COV_ERR: cover property (pslverr);
	COV_OK: cover property (pready && !pslverr);
	COV_STEP: cover property (lane_out[1].step == DE_6P2DB);
endmodule : slocfg_props

// >>> verif/slocfg_tb.sv
`timescale 1ns/1ns
module slocfg_tb;
	import slocfg_pkg::*;
	logic                   clk, rst, ce, psel, penable, pwrite, pready, pslverr, er;
	logic                   sync_diff_p, sync_diff_m, general_purpose_pin_four, sync_req_n;
	logic [7:0]             paddr;
	logic [31:0]            pwdata, prdata, rd;
	logic [3:0]             lane_data;
	slocfg_lane_out_t [3:0] lane_out;
	int                     n_errors = 0;
	int                     num_checks = 0;
	slocfg_top slocfg_top_i (
		.clk                      (clk),
		.rst                      (rst),
		.ce                       (ce),
		.psel                     (psel),
		.penable                  (penable),
		.pwrite                   (pwrite),
		.paddr                    (paddr),
		.pwdata                   (pwdata),
		.prdata                   (prdata),
		.pready                   (pready),
		.pslverr                  (pslverr),
		.lane_data                (lane_data),
		.lane_out                 (lane_out),
		.sync_diff_p              (sync_diff_p),
		.sync_diff_m              (sync_diff_m),
		.general_purpose_pin_four (general_purpose_pin_four),
		.sync_req_n               (sync_req_n)
	);
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic summarize;
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer; waits for pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 16) chk(32'h1, 32'h0);
	endtask : apb
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk({31'h0, er}, 32'h0);
	endtask : rdchk
	task automatic t_reset;
		logic [7:0] a[6] = '{8'h5c, 8'hc8, 8'hcc, 8'hd0, 8'hd4, 8'hd8};
		foreach (a[i]) rdchk(a[i], 32'h0);
	endtask : t_reset
	task automatic t_pol;
		slocfg_lane_out_t e;
		lane_data <= 4'b0110;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 8'h5c, 32'h70 | (32'h8 >> i));
			repeat (3) @(posedge clk);
			for (int j = 0; j < 4; j++) begin
				e = '{lane_data[j] ^ (i == j), ~(lane_data[j] ^ (i == j)), 6'h0, DE_NONE};
				chk(32'(lane_out[j]), 32'(e));
			end
		end
		rdchk(8'h5c, 32'h70);
	endtask : t_pol
	task automatic t_err;
		apb(1'b1, 8'h5d, 32'h0f);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, 8'h04, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		rdchk(8'h5c, 32'h70);
	endtask : t_err
	task automatic t_emp;
		logic [5:0] cd[5] = '{6'h00, 6'h01, 6'h03, 6'h07, 6'h0f};
		slocfg_step_t st[5] = '{DE_NONE, DE_1DB, DE_2DB, DE_4P1DB, DE_6P2DB};
		for (int c = 0; c < 5; c++) begin
			for (int i = 0; i < 4; i++) apb(1'b1, 8'hc8 + 8'(4 * i), {24'h0, cd[(c + i) % 5], 2'b11});
			repeat (3) @(posedge clk);
			for (int i = 0; i < 4; i++) begin
				chk({26'h0, lane_out[i].level}, {26'h0, cd[(c + i) % 5]});
				chk(32'(lane_out[i].step), 32'(st[(c + i) % 5]));
				rdchk(8'hc8 + 8'(4 * i), {24'h0, cd[(c + i) % 5], 2'b00});
			end
		end
		// A code with no defined strength
		apb(1'b1, 8'hc8, 32'h08);
		repeat (3) @(posedge clk);
		chk(32'(lane_out[0].step), 32'(DE_OTHER));
	endtask : t_emp
	task automatic t_sync;
		apb(1'b1, 8'hd8, 32'h0);
		sync_diff_p <= 1'b0;
		sync_diff_m <= 1'b1;
		repeat (3) @(posedge clk);
		chk({31'h0, sync_req_n}, 32'h0);
		apb(1'b1, 8'hd8, 32'h40);
		repeat (3) @(posedge clk);
		chk({31'h0, sync_req_n}, 32'h1);
		sync_diff_p <= 1'b1;
		sync_diff_m <= 1'b0;
		general_purpose_pin_four <= 1'b0;
		repeat (3) @(posedge clk);
		chk({31'h0, sync_req_n}, 32'h0);
		rdchk(8'hd8, 32'h40);
		// Status: request low, pin four selected, pair decision frozen at 0
		rdchk(8'hfc, 32'h2);
	endtask : t_sync
	// Mid-run reset returns registers, lanes and sync output to idle
	task automatic t_rerst;
		slocfg_lane_out_t e;
		e = '{1'b0, 1'b1, 6'h0, DE_NONE};
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		chk({31'h0, sync_req_n}, 32'h1);
		for (int j = 0; j < 4; j++) chk(32'(lane_out[j]), 32'(e));
		t_reset();
	endtask : t_rerst
	// Main sequence
	initial begin
		{rst, ce, psel, penable, pwrite, sync_diff_p, sync_diff_m, general_purpose_pin_four} = 8'hc5;
		{paddr, pwdata, lane_data} = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_pol();
		t_err();
		t_emp();
		t_sync();
		t_rerst();
		summarize();
	end
	// Watchdog
	initial begin
		repeat (4000) @(posedge clk);
		n_errors++;
		summarize();
	end
endmodule : slocfg_tb
bind slocfg_top slocfg_props slocfg_props_i (
	.clk                      (clk),
	.rst                      (rst),
	.psel                     (psel),
	.penable                  (penable),
	.paddr                    (paddr),
	.prdata                   (prdata),
	.pready                   (pready),
	.pslverr                  (pslverr),
	.lane_out                 (lane_out),
	.sync_diff_p              (sync_diff_p),
	.sync_diff_m              (sync_diff_m),
	.general_purpose_pin_four (general_purpose_pin_four),
	.sync_req_n               (sync_req_n)
);
